// >>> verilog/nqm_params.svh
/*
 Register offsets, field positions and reset values of the queued-command
 manager. Assumes inclusion by bare name from the design files.
*/
// Contract
// - Idle plus device interrupt moves to interrupt handling.
// - Queuing enabled and nothing to do: stay idle.
// - New queued command from software is appended to queue, then idle.
// - Tag preset gives a free tag, sets its map bit, then idle.
// - Issue sends the command FIS with tag when allowed, marks issued.
// - Blocked issue is deferred; command stays unissued; back to idle.
// - Interrupt state reads device status, clearing pending, and latches it.
// - Compare map with stored copy: completions retire, else error test.
// - Retire commands whose tag bits newly cleared; update stored copy.
// - Error flag clear keeps queue; set enters queue reset.
// - Queue reset asks for error log; PIO or DMA acceptance; else retry.
// - PIO wait polls until transfer request set and busy clear.
// - PIO retrieval waits for data FIS completion, then error flush.
// - Flush fails tagged commands, frees all tags, fails or keeps pending.
// - Idle with untagged command and free tag moves to tag preset.
// - Idle with tagged command, busy clear, no DMA phase: issue.
`ifndef NQM_PARAMS_SVH
`define NQM_PARAMS_SVH

`define NQM_OFF_CTRL    8'h00
`define NQM_OFF_CMD     8'h04
`define NQM_OFF_STATUS  8'h08
`define NQM_OFF_ACTIVE  8'h0c
`define NQM_OFF_ISSUED  8'h10
`define NQM_OFF_LSTAT   8'h14

`define NQM_CTRL_EN     0
`define NQM_CTRL_DMA    1
`define NQM_CTRL_REIS   2
`define NQM_CTRL_RST    3'h1

`define NQM_STS_CMD     14
`define NQM_STS_SLOT    16

`define NQM_ST_BSY      7
`define NQM_ST_DRQ      3
`define NQM_ST_ERR      0

`define NQM_OP_MAX      3'h4
`define NQM_LOG_MAX_DW  12'h800

`define NQM_RESP_OK     2'b00
`define NQM_RESP_ERR    2'b10

`endif

// >>> verilog/nqm_pkg.sv
/*
 Types of the queued-command manager: state codes and command opcodes.
 Assumes nothing of its surroundings.
*/
package nqm_pkg;

    typedef enum logic [13:0] {
        nqm_st_idle  = 14'h0001,
        nqm_st_add   = 14'h0002,
        nqm_st_pre   = 14'h0004,
        nqm_st_iss   = 14'h0008,
        nqm_st_int   = 14'h0010,
        nqm_st_cmp1  = 14'h0020,
        nqm_st_cmp2  = 14'h0040,
        nqm_st_cmp3  = 14'h0080,
        nqm_st_rstq  = 14'h0100,
        nqm_st_pwait = 14'h0200,
        nqm_st_precv = 14'h0400,
        nqm_st_drecv = 14'h0800,
        nqm_st_dstat = 14'h1000,
        nqm_st_flush = 14'h2000
    } nqm_state_t;

    typedef enum logic [2:0] {
        nqm_op_read    = 3'h0,
        nqm_op_write   = 3'h1,
        nqm_op_nondata = 3'h2,
        nqm_op_receive = 3'h3,
        nqm_op_send    = 3'h4
    } nqm_op_t;

endpackage

// >>> verilog/nqm_first_set.sv
/*
 Lowest set bit finder used for slot and tag allocation.
 Assumes a vector of at least two bits.
*/
module nqm_first_set #(
    parameter int N = 32,
    parameter int W = 5
) (
    input  wire logic [N-1:0] vec,
    output logic              found,
    output logic [W-1:0]      idx
);

    always_comb begin
        found = |vec;
        idx   = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = W'(i);
            end
        end
    end

endmodule

// >>> verilog/nqm_host_queue_manager.sv
/*
 Host command-layer manager for native queued commands: queue, tag map,
 command issue, completion retirement and error-log recovery, with an
 AXI4-Lite register slave. Assumes transport-side signals on aclk.
*/
// The register addresses and register access over AXI4-Lite were left to the implementer.
`include "nqm_params.svh"

module nqm_host_queue_manager #(
    parameter int QD = 32
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [7:0]         awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [7:0]         araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    input  wire logic               dev_intr,
    input  wire logic [7:0]         dev_status,
    output logic                    status_rd,
    input  wire logic               sdb_valid,
    input  wire logic [31:0]        sdb_clear,
    input  wire logic               iface_permit,
    input  wire logic               first_party_dma,
    output logic                    h2d_valid,
    output nqm_pkg::nqm_op_t        h2d_op,
    output logic [4:0]              h2d_tag,
    output logic                    log_req,
    output logic                    log_dma,
    input  wire logic               log_ack_pio,
    input  wire logic               log_ack_dma,
    input  wire logic               pio_fis_done,
    input  wire logic               dma_fis_done,
    input  wire logic               d2h_fis_done,
    output logic                    retire_valid,
    output logic [31:0]             retire_mask,
    output logic                    retire_err
);

    localparam int TW = $clog2(QD);

    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    nqm_pkg::nqm_state_t state;
    nqm_pkg::nqm_state_t next_state;
    logic [2:0]          ctrl;
    logic                cmd_req;
    nqm_pkg::nqm_op_t    cmd_op;
    logic [QD-1:0]       slot_used;
    logic [QD-1:0]       slot_tagged;
    logic [QD-1:0]       slot_issued;
    nqm_pkg::nqm_op_t    slot_op [QD];
    logic [4:0]          slot_tag [QD];
    logic [31:0]         active_tag_map;
    logic [31:0]         saved_map;
    logic [7:0]          latched_status;
    logic [TW-1:0]       last_slot;
    logic [QD-1:0]       slot_done;
    logic                free_slot_ok;
    logic [TW-1:0]       free_slot;
    logic                untag_ok;
    logic [TW-1:0]       untag_slot;
    logic                unis_ok;
    logic [TW-1:0]       unis_slot;
    logic                free_tag_ok;
    logic [4:0]          free_tag;

    wire in_idle  = state == nqm_pkg::nqm_st_idle;
    wire in_add   = state == nqm_pkg::nqm_st_add;
    wire in_pre   = state == nqm_pkg::nqm_st_pre;
    wire in_iss   = state == nqm_pkg::nqm_st_iss;
    wire in_int   = state == nqm_pkg::nqm_st_int;
    wire in_cmp1  = state == nqm_pkg::nqm_st_cmp1;
    wire in_cmp2  = state == nqm_pkg::nqm_st_cmp2;
    wire in_cmp3  = state == nqm_pkg::nqm_st_cmp3;
    wire in_rstq  = state == nqm_pkg::nqm_st_rstq;
    wire in_pwait = state == nqm_pkg::nqm_st_pwait;
    wire in_precv = state == nqm_pkg::nqm_st_precv;
    wire in_flush = state == nqm_pkg::nqm_st_flush;

    // ------------------------------------------------------------
    // Allocation and completion decode
    // ------------------------------------------------------------
    nqm_first_set #(.N(QD), .W(TW)) u_free_slot (
        .vec   (~slot_used),
        .found (free_slot_ok),
        .idx   (free_slot)
    );
    nqm_first_set #(.N(QD), .W(TW)) u_untag (
        .vec   (slot_used & ~slot_tagged),
        .found (untag_ok),
        .idx   (untag_slot)
    );
    nqm_first_set #(.N(QD), .W(TW)) u_unissued (
        .vec   (slot_tagged & ~slot_issued),
        .found (unis_ok),
        .idx   (unis_slot)
    );
    // Tags stay reserved until retired, not just until the device clears them
    nqm_first_set #(.N(32), .W(5)) u_free_tag (
        .vec   (~(active_tag_map | saved_map)),
        .found (free_tag_ok),
        .idx   (free_tag)
    );

    wire        q_en      = ctrl[`NQM_CTRL_EN];
    wire [31:0] done_map  = saved_map & ~active_tag_map;
    wire        go_add    = q_en & cmd_req & free_slot_ok;
    wire        go_pre    = q_en & untag_ok & free_tag_ok;
    wire        go_iss    = q_en & unis_ok & ~dev_status[`NQM_ST_BSY] & ~first_party_dma;
    wire        iss_go    = in_iss & iface_permit;
    wire [4:0]  iss_tag   = slot_tag[unis_slot];
    wire        pio_ready = dev_status[`NQM_ST_DRQ] & ~dev_status[`NQM_ST_BSY];
    wire [31:0] pre_bit   = in_pre ? (32'h1 << free_tag) : 32'h0;
    wire [QD-1:0] one_hot = {{(QD - 1){1'b0}}, 1'b1};
    wire [QD-1:0] add_oh  = in_add ? (one_hot << free_slot) : '0;
    wire [QD-1:0] pre_oh  = in_pre ? (one_hot << untag_slot) : '0;
    wire [QD-1:0] iss_oh  = iss_go ? (one_hot << unis_slot) : '0;
    wire [QD-1:0] fl_mask = slot_tagged | (ctrl[`NQM_CTRL_REIS] ? '0 : slot_used);
    wire [QD-1:0] kill    = in_cmp2 ? slot_done : (in_flush ? fl_mask : '0);
    wire [31:0]   sdb_clr = sdb_valid ? sdb_clear : 32'h0;

    genvar g;
    generate
        for (g = 0; g < QD; g++) begin : g_done
            assign slot_done[g] = slot_tagged[g] & done_map[slot_tag[g]];
        end
    endgenerate

    assign status_rd = in_int;
    assign log_req   = in_rstq;

    // ------------------------------------------------------------
    // Command-layer state machine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            nqm_pkg::nqm_st_idle: begin
                if (dev_intr) begin
                    next_state = nqm_pkg::nqm_st_int;
                end else if (go_add) begin
                    next_state = nqm_pkg::nqm_st_add;
                end else if (go_pre) begin
                    next_state = nqm_pkg::nqm_st_pre;
                end else if (go_iss) begin
                    next_state = nqm_pkg::nqm_st_iss;
                end else begin
                    next_state = nqm_pkg::nqm_st_idle;
                end
            end
            nqm_pkg::nqm_st_add:  next_state = nqm_pkg::nqm_st_idle;
            nqm_pkg::nqm_st_pre:  next_state = nqm_pkg::nqm_st_idle;
            nqm_pkg::nqm_st_iss:  next_state = nqm_pkg::nqm_st_idle;
            nqm_pkg::nqm_st_int:  next_state = nqm_pkg::nqm_st_cmp1;
            nqm_pkg::nqm_st_cmp1: begin
                next_state = (|done_map) ? nqm_pkg::nqm_st_cmp2 : nqm_pkg::nqm_st_cmp3;
            end
            nqm_pkg::nqm_st_cmp2: next_state = nqm_pkg::nqm_st_cmp3;
            nqm_pkg::nqm_st_cmp3: begin
                next_state = latched_status[`NQM_ST_ERR] ? nqm_pkg::nqm_st_rstq
                                                         : nqm_pkg::nqm_st_idle;
            end
            nqm_pkg::nqm_st_rstq: begin
                if (log_ack_pio) begin
                    next_state = nqm_pkg::nqm_st_pwait;
                end else if (log_ack_dma) begin
                    next_state = nqm_pkg::nqm_st_drecv;
                end
            end
            nqm_pkg::nqm_st_pwait: begin
                if (pio_ready) begin
                    next_state = nqm_pkg::nqm_st_precv;
                end
            end
            nqm_pkg::nqm_st_precv: begin
                if (pio_fis_done) begin
                    next_state = nqm_pkg::nqm_st_flush;
                end
            end
            nqm_pkg::nqm_st_drecv: begin
                if (dma_fis_done) begin
                    next_state = nqm_pkg::nqm_st_dstat;
                end
            end
            nqm_pkg::nqm_st_dstat: begin
                if (d2h_fis_done) begin
                    next_state = nqm_pkg::nqm_st_flush;
                end
            end
            nqm_pkg::nqm_st_flush: next_state = nqm_pkg::nqm_st_idle;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= nqm_pkg::nqm_st_idle;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Queue slots and tag maps
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slot_used   <= '0;
            slot_tagged <= '0;
            slot_issued <= '0;
        end else begin
            slot_used   <= (slot_used | add_oh) & ~kill;
            slot_tagged <= (slot_tagged | pre_oh) & ~kill;
            slot_issued <= (slot_issued | iss_oh) & ~kill;
        end
    end

    always_ff @(posedge aclk) begin
        if (in_add) begin
            slot_op[free_slot] <= cmd_op;
        end
        if (in_pre) begin
            slot_tag[untag_slot] <= free_tag;
        end
    end

    // Device clears and a preset in the same cycle: the preset wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_tag_map <= 32'h0;
            saved_map      <= 32'h0;
        end else if (in_flush) begin
            active_tag_map <= 32'h0;
            saved_map      <= 32'h0;
        end else begin
            active_tag_map <= (active_tag_map & ~sdb_clr) | pre_bit;
            saved_map      <= in_cmp2 ? active_tag_map : (saved_map | pre_bit);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latched_status <= 8'h00;
            h2d_valid      <= 1'b0;
            h2d_op         <= nqm_pkg::nqm_op_read;
            h2d_tag        <= 5'h00;
            last_slot      <= '0;
        end else begin
            h2d_valid <= iss_go;
            if (in_int) begin
                latched_status <= dev_status;
            end
            if (iss_go) begin
                h2d_op  <= slot_op[unis_slot];
                h2d_tag <= iss_tag;
            end
            if (in_add) begin
                last_slot <= free_slot;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            retire_valid <= 1'b0;
            retire_mask  <= 32'h0;
            retire_err   <= 1'b0;
        end else begin
            retire_valid <= |kill;
            retire_mask  <= 32'(kill);
            retire_err   <= in_flush;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_strb0;

    wire do_wr   = aw_held & w_held & ~bvalid;
    wire wr_ctrl = aw_addr == `NQM_OFF_CTRL;
    wire cmd_ok  = (aw_addr == `NQM_OFF_CMD) & ~cmd_req & w_strb0
                   & (w_data[2:0] <= `NQM_OP_MAX);
    wire wr_ok   = wr_ctrl | cmd_ok;

    assign awready = ~aw_held;
    assign wready  = ~w_held;
    assign arready = ~rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0;
            w_strb0 <= 1'b0;
        end else begin
            if (awvalid & ~aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (do_wr) begin
                aw_held <= 1'b0;
            end
            if (wvalid & ~w_held) begin
                w_held  <= 1'b1;
                w_data  <= wdata;
                w_strb0 <= wstrb[0];
            end else if (do_wr) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid  <= 1'b0;
            bresp   <= `NQM_RESP_OK;
            ctrl    <= `NQM_CTRL_RST;
            cmd_req <= 1'b0;
            cmd_op  <= nqm_pkg::nqm_op_read;
            log_dma <= 1'b0;
        end else begin
            log_dma <= ctrl[`NQM_CTRL_DMA];
            if (do_wr) begin
                bvalid <= 1'b1;
                bresp  <= wr_ok ? `NQM_RESP_OK : `NQM_RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (do_wr & wr_ctrl & w_strb0) begin
                ctrl <= w_data[2:0];
            end
            if (do_wr & cmd_ok) begin
                cmd_req <= 1'b1;
                cmd_op  <= nqm_pkg::nqm_op_t'(w_data[2:0]);
            end else if (in_add) begin
                cmd_req <= 1'b0;
            end
        end
    end

    wire [31:0] status_word = {11'h0, 5'(last_slot), 1'b0, cmd_req, 14'(state)};
    wire        rd_hit = (araddr == `NQM_OFF_CTRL) | (araddr == `NQM_OFF_CMD)
                       | (araddr == `NQM_OFF_STATUS) | (araddr == `NQM_OFF_ACTIVE)
                       | (araddr == `NQM_OFF_ISSUED) | (araddr == `NQM_OFF_LSTAT);
    wire [31:0] rd_word =
        (araddr == `NQM_OFF_CTRL)   ? {29'h0, ctrl} :
        (araddr == `NQM_OFF_CMD)    ? {29'h0, cmd_op} :
        (araddr == `NQM_OFF_STATUS) ? status_word :
        (araddr == `NQM_OFF_ACTIVE) ? active_tag_map :
        (araddr == `NQM_OFF_ISSUED) ? 32'(slot_issued) :
        (araddr == `NQM_OFF_LSTAT)  ? {24'h0, latched_status} : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `NQM_RESP_OK;
        end else if (arvalid & ~rvalid) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? `NQM_RESP_OK : `NQM_RESP_ERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_int_seen;
        in_idle && dev_intr;
    endsequence
    sequence s_int_done;
        in_int && status_rd ##1 in_cmp1;
    endsequence
    sequence s_err_set;
        in_cmp3 && latched_status[`NQM_ST_ERR];
    endsequence

    a_idle_intr_entry: assert property (s_int_seen |=> s_int_done)
        else $error("interrupt not handled from idle");
    a_idle_hold: assert property (in_idle && !dev_intr && !go_add && !go_pre && !go_iss
        |=> in_idle)
        else $error("idle left without cause");
    a_add_append: assert property (in_add |=> in_idle && !cmd_req
        && $countones(slot_used) == $countones($past(slot_used)) + 1)
        else $error("command not appended");
    a_preset_tag: assert property (in_pre |=> in_idle
        && active_tag_map[$past(free_tag)])
        else $error("preset tag bit missing");
    a_issue_send: assert property (in_iss && iface_permit |=> h2d_valid
        && h2d_tag == $past(iss_tag) && in_idle)
        else $error("issue FIS wrong");
    a_issue_defer: assert property (in_iss && !iface_permit |=> !h2d_valid
        && in_idle && slot_issued == $past(slot_issued))
        else $error("blocked issue not deferred");
    a_int_latch: assert property (in_int |=> latched_status == $past(dev_status))
        else $error("status not latched");
    a_cmp_branch: assert property (in_cmp1 |=> (($past(done_map) != 32'h0) ? in_cmp2 : in_cmp3))
        else $error("completion branch wrong");
    a_retire_update: assert property (in_cmp2 |=> in_cmp3 && retire_valid
        && saved_map == $past(active_tag_map))
        else $error("retire or map copy wrong");
    a_err_test: assert property (s_err_set |=> in_rstq)
        else $error("error flag not acted on");
    a_err_clear: assert property (in_cmp3 && !latched_status[`NQM_ST_ERR] |=> in_idle)
        else $error("queue not kept");
    a_log_branch: assert property (in_rstq && log_req && !log_ack_pio && !log_ack_dma
        |=> in_rstq && log_req)
        else $error("log request not retried");
    a_pio_poll: assert property (in_pwait |=> (($past(pio_ready)) ? in_precv : in_pwait))
        else $error("PIO wait wrong");
    a_pio_done: assert property (in_precv && pio_fis_done |=> state == nqm_pkg::nqm_st_flush)
        else $error("PIO retrieval did not flush");
    a_flush_clear: assert property (in_flush |=> in_idle && active_tag_map == 32'h0
        && retire_err ##1 !retire_err)
        else $error("flush incomplete");
    a_idle_preset: assert property (in_idle && !dev_intr && !go_add && go_pre |=> in_pre)
        else $error("preset not entered");
    a_idle_issue: assert property (in_idle && !dev_intr && !go_add && !go_pre && go_iss
        |=> in_iss)
        else $error("issue not entered");
    a_intr_first: assert property (in_idle && dev_intr && (go_iss || go_pre)
        |=> in_int)
        else $error("interrupt lost priority");

endmodule

// >>> dv/nqm_dev_model.sv
/* Storage device model facing the queue manager's transport side.
   Assumes the manager's ports on aclk; bench drives intr_raise and fault. */
module nqm_dev_model (
    input  wire logic       aclk,
    input  wire logic       intr_raise,
    input  wire logic       fault,
    input  wire logic       status_rd,
    input  wire logic       log_req,
    input  wire logic       log_dma,
    output logic            dev_intr,
    output logic [7:0]      dev_status,
    output logic            log_ack_pio,
    output logic            log_ack_dma,
    output logic            pio_fis_done,
    output logic            dma_fis_done,
    output logic            d2h_fis_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int n = 0;
    initial dev_intr = 1'b0;
    // Log step counter: busy, ack, transfer request, data FIS, status FIS
    always @(posedge aclk) begin
        if (intr_raise) dev_intr <= 1'b1;
        else if (status_rd) dev_intr <= 1'b0;
        if (n == 12) n <= 0;
        else if (n > 0 || log_req) n <= n + 1;
    end
    assign dev_status = {n inside {[1:5]}, 3'h0, n > 5 && !log_dma, 2'h0, fault};
    assign log_ack_pio = n == 3 && !log_dma;
    assign log_ack_dma = n == 3 && log_dma;
    assign pio_fis_done = n == 9 && !log_dma;
    assign dma_fis_done = n == 7 && log_dma;
    assign d2h_fis_done = n == 10 && log_dma;
endmodule

// >>> dv/tb_nqm_host_queue_manager.sv
/* Self-checking bench of the queue manager with the device model.
   Assumes the manager's AXI4-Lite map and transport ports. */
module tb_nqm_host_queue_manager;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sdb_valid = 0, iface_permit = 1, first_party_dma = 0, intr_raise = 0, fault = 0;
    logic [7:0] awaddr = 0, araddr = 0, dev_status;
    logic [31:0] wdata = 0, sdb_clear = 0, rdata, retire_mask, rv;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp;
    logic [4:0] h2d_tag;
    logic awready, wready, bvalid, arready, rvalid, status_rd, h2d_valid, log_req, log_dma;
    logic retire_valid, retire_err, dev_intr, log_ack_pio, log_ack_dma;
    logic pio_fis_done, dma_fis_done, d2h_fis_done;
    nqm_pkg::nqm_op_t h2d_op;
    int err_count = 0, compares = 0;
    nqm_host_queue_manager uut (.*);
    nqm_dev_model dev (.*);
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(32'(bresp), 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, exp);
        chk(32'(rresp), 32'h0);
    endtask
    task automatic wait_hi(ref logic s);
        for (int i = 0; i < 60 && s !== 1'b1; i++) @(posedge aclk);
        chk(32'(s), 32'h1);
    endtask
    task automatic pulse_intr(input logic f);
        fault <= f;
        intr_raise <= 1'b1;
        @(posedge aclk);
        intr_raise <= 1'b0;
    endtask
    task automatic s_reset();
        rd(8'h08, 32'h1);
        rd(8'h00, 32'h1);
    endtask
    task automatic s_issue();
        for (int i = 0; i < 5; i++) begin
            wr(8'h04, 32'(i));
            wait_hi(h2d_valid);
            chk(32'(h2d_op), 32'(i));
            chk(32'(h2d_tag), 32'(i));
        end
        rd(8'h0c, 32'h1f);
        rd(8'h10, 32'h1f);
    endtask
    task automatic s_defer();
        iface_permit <= 1'b0;
        wr(8'h04, 32'h2);
        repeat (20) @(posedge aclk);
        pulse_intr(1'b0);
        wait_hi(status_rd);
        rd(8'h10, 32'h1f);
        first_party_dma <= 1'b1;
        repeat (2) @(posedge aclk);
        iface_permit <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(8'h10, 32'h1f);
        first_party_dma <= 1'b0;
        wait_hi(h2d_valid);
        chk(32'(h2d_tag), 32'h5);
    endtask
    task automatic s_complete();
        sdb_clear <= 32'h3;
        sdb_valid <= 1'b1;
        @(posedge aclk);
        sdb_valid <= 1'b0;
        pulse_intr(1'b0);
        wait_hi(status_rd);
        wait_hi(retire_valid);
        chk(retire_mask, 32'h3);
        chk(32'(retire_err), 32'h0);
        rd(8'h0c, 32'h3c);
        rd(8'h08, 32'h00050001);
    endtask
    task automatic s_error(input logic dma, input logic [31:0] mask, input logic [31:0] sts);
        pulse_intr(1'b1);
        wait_hi(log_req);
        chk(32'(log_dma), 32'(dma));
        wait_hi(retire_err);
        chk(retire_mask, mask);
        fault <= 1'b0;
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h1);
        rd(8'h08, sts);
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        s_reset();
        s_issue();
        s_defer();
        s_complete();
        s_error(1'b0, 32'h3c, 32'h00050001);
        wr(8'h00, 32'h3);
        wr(8'h04, 32'h0);
        wait_hi(h2d_valid);
        s_error(1'b1, 32'h1, 32'h1);
        summarize();
    end
    initial begin
        #60us;
        err_count++;
        summarize();
    end
endmodule
